/* File: logic/ilh_pkg.sv */
package ilh_pkg;
  // register word addresses
  localparam logic [15:0] ADDR_HW_PEND = 16'h0006;
  localparam logic [15:0] ADDR_CNT_PTR = 16'h000a;
  localparam logic [15:0] ADDR_HW_EN   = 16'h000f;
  localparam logic [15:0] ADDR_HW_LINE = 16'h0013;
  localparam logic [15:0] ADDR_EXT_CFG = 16'h004d;
  // log buffer geometry
  localparam logic [8:0]  LOG_BASE     = 9'h180;
  localparam logic [8:0]  LOG_LAST     = 9'h1be;
  localparam logic [8:0]  LOG_STEP     = 9'h002;
  localparam logic [6:0]  CNT_MAX      = 7'h7f;
  localparam logic [6:0]  CNT_ONE      = 7'h01;
  // reset values
  localparam logic [15:0] CNT_PTR_RST  = 16'h0180;
  localparam logic [15:0] HW_EN_RST    = 16'h6000;
  localparam logic [15:0] HW_LINE_RST  = 16'h6000;
  localparam logic        BUSY_TAG_RST = 1'b0;
  // field positions and masks
  localparam logic [15:0] EVT_MASK     = 16'hfff8;
  localparam int          RT_SUM_BIT   = 2;
  localparam int          PARITY_BIT   = 14;
  localparam int          FRAMING_BIT  = 15;
  localparam int          BUSY_BIT     = 9;
  localparam int          BUSY_TAG_BIT = 2;
  localparam logic [15:0] HW_LOC_NONE  = 16'h0000;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;

  // one log record
  typedef struct packed {
    logic [15:0] ident;
    logic [15:0] loc;
  } ilh_rec_t;

  // one RAM write
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
  } ilh_ram_wr_t;

  typedef enum logic [1:0] {
    ILH_IDLE   = 2'b00,
    ILH_WR_ID  = 2'b01,
    ILH_WR_LOC = 2'b11
  } ilh_log_st_t;
endpackage

/* File: logic/ilh_event_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module ilh_event_capture (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // events and enables
  input  wire logic [15:0] evt_i,
  input  wire logic [15:0] enable_i,
  input  wire logic        rd_clr_i,
  // captured flags
  output logic      [15:0] pend_o
);
  logic [15:0] pend_reg;
  logic [15:0] pend_next;

  // new events win over the read clear so none is lost
  always_comb begin
    pend_next = (rd_clr_i ? ilh_pkg::WORD_ZERO : pend_reg)
              | (evt_i & enable_i & ilh_pkg::EVT_MASK);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_reg <= 16'h0000;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign pend_o = pend_reg;

  a_pend_gated: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_clr_i |=> (pend_reg & ~($past(evt_i) & $past(enable_i))) == 16'h0000)
    else $error("pending flag set without enabled event");
  a_read_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_clr_i && (evt_i & enable_i) == 16'h0000) |=> pend_reg == 16'h0000)
    else $error("pending register not cleared by read");
endmodule
`default_nettype wire

/* File: logic/ilh_log_writer.sv */
`timescale 1ns/1ps
`default_nettype none
module ilh_log_writer (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  // record request
  input  wire logic                  rec_valid_i,
  input  wire ilh_pkg::ilh_rec_t     rec_i,
  output logic                       rec_ready_o,
  // count and pointer register
  input  wire logic                  cnt_clr_i,
  output logic [15:0]                cnt_ptr_o,
  // log RAM write port
  output var ilh_pkg::ilh_ram_wr_t   ram_wr_o
);
  ilh_pkg::ilh_log_st_t st_reg;
  ilh_pkg::ilh_log_st_t st_next;
  ilh_pkg::ilh_rec_t    rec_reg;
  ilh_pkg::ilh_rec_t    rec_next;
  ilh_pkg::ilh_ram_wr_t wr_reg;
  ilh_pkg::ilh_ram_wr_t wr_next;
  logic [8:0]           ptr_reg;
  logic [8:0]           ptr_next;
  logic [6:0]           cnt_reg;
  logic [6:0]           cnt_next;

  assign rec_ready_o = (st_reg == ilh_pkg::ILH_IDLE);

  // three cycles per record: accept, ident word, location word
  always_comb begin
    st_next  = st_reg;
    rec_next = rec_reg;
    wr_next  = '0;
    ptr_next = ptr_reg;
    cnt_next = cnt_clr_i ? 7'h00 : cnt_reg;
    case (st_reg)
      ilh_pkg::ILH_IDLE: begin
        if (rec_valid_i) begin
          rec_next = rec_i;
          wr_next  = '{we: 1'b1, addr: {7'h00, ptr_reg}, data: rec_i.ident};
          st_next  = ilh_pkg::ILH_WR_ID;
        end
      end
      ilh_pkg::ILH_WR_ID: begin
        wr_next = '{we: 1'b1, addr: {7'h00, ptr_reg | 9'h001}, data: rec_reg.loc};
        st_next = ilh_pkg::ILH_WR_LOC;
      end
      ilh_pkg::ILH_WR_LOC: begin
        // the pointer only moves once the pair is complete
        ptr_next = (ptr_reg == ilh_pkg::LOG_LAST) ? ilh_pkg::LOG_BASE
                 : ptr_reg + ilh_pkg::LOG_STEP;
        if (cnt_next != ilh_pkg::CNT_MAX) begin
          cnt_next = cnt_next + ilh_pkg::CNT_ONE;
        end
        st_next = ilh_pkg::ILH_IDLE;
      end
      default: begin
        st_next = ilh_pkg::ILH_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg  <= ilh_pkg::ILH_IDLE;
      rec_reg <= '0;
      wr_reg  <= '0;
      ptr_reg <= ilh_pkg::CNT_PTR_RST[8:0];
      cnt_reg <= ilh_pkg::CNT_PTR_RST[15:9];
    end else begin
      st_reg  <= st_next;
      rec_reg <= rec_next;
      wr_reg  <= wr_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
    end
  end

  assign cnt_ptr_o = {cnt_reg, ptr_reg};
  assign ram_wr_o  = wr_reg;

  a_ptr_wrap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (st_reg == ilh_pkg::ILH_WR_LOC && ptr_reg == ilh_pkg::LOG_LAST)
      |=> ptr_reg == ilh_pkg::LOG_BASE)
    else $error("log pointer did not wrap");
  a_ptr_range: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ptr_reg[8:6] == 3'b110 && !ptr_reg[0])
    else $error("log pointer out of buffer");
  a_word_pair: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rec_valid_i && rec_ready_o) |=> (wr_reg.we && !wr_reg.addr[0]
      && wr_reg.data == $past(rec_i.ident)) ##1 (wr_reg.we && wr_reg.addr[0]
      && wr_reg.data == $past(rec_i.loc, 2)) ##1 !wr_reg.we)
    else $error("log record not written as ident then location pair");
  a_cnt_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cnt_reg == ilh_pkg::CNT_MAX && !cnt_clr_i) |=> cnt_reg == ilh_pkg::CNT_MAX)
    else $error("log count passed its limit");
  c_wrap: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_reg == ilh_pkg::ILH_WR_LOC && ptr_reg == ilh_pkg::LOG_LAST);
endmodule
`default_nettype wire

/* File: logic/ilh_int_log.sv */
`timescale 1ns/1ps
`default_nettype none
module ilh_int_log (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  // register access from the host port logic
  input  wire logic                  reg_rd_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [15:0]           reg_addr_i,
  input  wire logic [15:0]           reg_wdata_i,
  output logic [15:0]                reg_rdata_o,
  // hardware event sources, one-cycle pulses
  input  wire logic [15:0]           hw_event_i,
  input  wire logic                  host_serial_framing_event_i,
  input  wire logic                  ram_parity_fault_i,
  input  wire logic [15:0]           ram_parity_addr_i,
  // terminal side, already enable gated by the terminal triplet
  input  wire logic [15:0]           rt_event_i,
  input  wire logic [15:0]           rt_desc_addr_i,
  input  wire logic                  rt_busy_i,
  input  wire logic                  rt_pend_any_i,
  input  wire logic                  rt_irq_i,
  // host interrupt and log RAM port
  output logic                       irq_n_o,
  output var ilh_pkg::ilh_ram_wr_t   ram_wr_o
);
  logic [15:0]       hw_en_reg;
  logic [15:0]       hw_en_next;
  logic [15:0]       hw_line_reg;
  logic [15:0]       hw_line_next;
  logic              busy_tag_reg;
  logic              busy_tag_next;
  logic [15:0]       rdata_reg;
  logic [15:0]       rdata_next;
  logic              irq_n_reg;
  logic              irq_n_next;
  ilh_pkg::ilh_rec_t hw_q_reg;
  ilh_pkg::ilh_rec_t hw_q_next;
  logic              hw_v_reg;
  logic              hw_v_next;
  ilh_pkg::ilh_rec_t rt_q_reg;
  ilh_pkg::ilh_rec_t rt_q_next;
  logic              rt_v_reg;
  logic              rt_v_next;

  logic [15:0]       hw_evt;
  logic [15:0]       hw_log;
  logic              par_log;
  logic [15:0]       rt_ident;
  logic [15:0]       hw_pend;
  logic [15:0]       hw_pend_view;
  logic              pend_rd;
  logic              cnt_rd;
  logic              wr_ready;
  logic              hw_take;
  logic              rt_take;
  logic              hw_keep;
  logic              rt_keep;
  logic [15:0]       cnt_ptr;
  ilh_pkg::ilh_rec_t wr_rec;

  // gather hardware sources into pending layout
  always_comb begin
    hw_evt = hw_event_i & ilh_pkg::EVT_MASK;
    hw_evt[ilh_pkg::FRAMING_BIT] = hw_event_i[ilh_pkg::FRAMING_BIT]
                                 | host_serial_framing_event_i;
    hw_evt[ilh_pkg::PARITY_BIT]  = hw_event_i[ilh_pkg::PARITY_BIT]
                                 | ram_parity_fault_i;
  end

  // only events whose enable was already set are recognised
  assign hw_log  = hw_evt & hw_en_reg & ilh_pkg::EVT_MASK;
  assign par_log = ram_parity_fault_i & hw_en_reg[ilh_pkg::PARITY_BIT];

  // terminal ident word: bit 2 marks a terminal record
  always_comb begin
    rt_ident = rt_event_i & ilh_pkg::EVT_MASK;
    rt_ident[ilh_pkg::RT_SUM_BIT] = 1'b1;
    if (busy_tag_reg) begin
      rt_ident[ilh_pkg::BUSY_BIT] = rt_busy_i;
    end
  end

  // read side effects decoded once; a read strobe lasts a single cycle
  assign pend_rd = reg_rd_i && (reg_addr_i == ilh_pkg::ADDR_HW_PEND);
  assign cnt_rd  = reg_rd_i && (reg_addr_i == ilh_pkg::ADDR_CNT_PTR);

  // pending flags; a clear that meets a new event keeps the event
  ilh_event_capture u_hw_pend (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .evt_i     (hw_evt),
    .enable_i  (hw_en_reg),
    .rd_clr_i  (pend_rd),
    .pend_o    (hw_pend)
  );

  // summary bit follows terminal pending directly, never stored here
  always_comb begin
    hw_pend_view = hw_pend & ilh_pkg::EVT_MASK;
    hw_pend_view[ilh_pkg::RT_SUM_BIT] = rt_pend_any_i;
  end

  // terminal records go first; they carry a message context
  assign rt_take = wr_ready && rt_v_reg;
  assign hw_take = wr_ready && hw_v_reg && !rt_v_reg;
  assign hw_keep = hw_v_reg && !hw_take;
  assign rt_keep = rt_v_reg && !rt_take;
  assign wr_rec  = rt_v_reg ? rt_q_reg : hw_q_reg;

  // record queues merge events that arrive while a record waits
  always_comb begin
    hw_q_next.ident = (hw_keep ? hw_q_reg.ident : ilh_pkg::WORD_ZERO) | hw_log;
    hw_q_next.loc   = hw_keep ? hw_q_reg.loc : ilh_pkg::HW_LOC_NONE;
    if (par_log) begin
      hw_q_next.loc = ram_parity_addr_i;
    end
    hw_v_next = hw_keep || (hw_log != ilh_pkg::WORD_ZERO);
    rt_q_next = rt_keep ? rt_q_reg : '0;
    rt_v_next = rt_keep;
    // busy with no event is not a cause and leaves the queue alone
    if ((rt_event_i & ilh_pkg::EVT_MASK) != ilh_pkg::WORD_ZERO) begin
      rt_q_next.ident = (rt_keep ? rt_q_reg.ident : ilh_pkg::WORD_ZERO) | rt_ident;
      rt_q_next.loc   = rt_keep ? rt_q_reg.loc : rt_desc_addr_i;
      rt_v_next       = 1'b1;
    end
  end

  // one writer serves both queues and takes a record only when idle
  ilh_log_writer u_writer (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .rec_valid_i (rt_v_reg || hw_v_reg),
    .rec_i       (wr_rec),
    .rec_ready_o (wr_ready),
    .cnt_clr_i   (cnt_rd),
    .cnt_ptr_o   (cnt_ptr),
    .ram_wr_o    (ram_wr_o)
  );

  // writable registers; unused low bits are not stored
  always_comb begin
    hw_en_next    = hw_en_reg;
    hw_line_next  = hw_line_reg;
    busy_tag_next = busy_tag_reg;
    if (reg_wr_i) begin
      if (reg_addr_i == ilh_pkg::ADDR_HW_EN) begin
        hw_en_next = reg_wdata_i & ilh_pkg::EVT_MASK;
      end else if (reg_addr_i == ilh_pkg::ADDR_HW_LINE) begin
        hw_line_next = reg_wdata_i & ilh_pkg::EVT_MASK;
      end else if (reg_addr_i == ilh_pkg::ADDR_EXT_CFG) begin
        busy_tag_next = reg_wdata_i[ilh_pkg::BUSY_TAG_BIT];
      end
    end
  end

  // read data is registered; unmapped addresses read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      if (reg_addr_i == ilh_pkg::ADDR_HW_PEND) begin
        rdata_next = hw_pend_view;
      end else if (reg_addr_i == ilh_pkg::ADDR_CNT_PTR) begin
        rdata_next = cnt_ptr;
      end else if (reg_addr_i == ilh_pkg::ADDR_HW_EN) begin
        rdata_next = hw_en_reg;
      end else if (reg_addr_i == ilh_pkg::ADDR_HW_LINE) begin
        rdata_next = hw_line_reg;
      end else if (reg_addr_i == ilh_pkg::ADDR_EXT_CFG) begin
        rdata_next = ilh_pkg::WORD_ZERO;
        rdata_next[ilh_pkg::BUSY_TAG_BIT] = busy_tag_reg;
      end else begin
        rdata_next = ilh_pkg::WORD_ZERO;
      end
    end
  end

  // one shared line: any line-enabled flag holds it low until read
  always_comb begin
    irq_n_next = !(((hw_pend & hw_line_reg & ilh_pkg::EVT_MASK) != ilh_pkg::WORD_ZERO)
                   || rt_irq_i);
  end

  // all register state of this level shares the one async reset
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hw_en_reg    <= ilh_pkg::HW_EN_RST;
      hw_line_reg  <= ilh_pkg::HW_LINE_RST;
      busy_tag_reg <= ilh_pkg::BUSY_TAG_RST;
      rdata_reg    <= 16'h0000;
      irq_n_reg    <= 1'b1;
      hw_q_reg     <= '0;
      hw_v_reg     <= 1'b0;
      rt_q_reg     <= '0;
      rt_v_reg     <= 1'b0;
    end else begin
      hw_en_reg    <= hw_en_next;
      hw_line_reg  <= hw_line_next;
      busy_tag_reg <= busy_tag_next;
      rdata_reg    <= rdata_next;
      irq_n_reg    <= irq_n_next;
      hw_q_reg     <= hw_q_next;
      hw_v_reg     <= hw_v_next;
      rt_q_reg     <= rt_q_next;
      rt_v_reg     <= rt_v_next;
    end
  end

  // both outputs come straight from flip-flops, so no glitch reaches the host
  assign reg_rdata_o = rdata_reg;
  assign irq_n_o     = irq_n_reg;

  a_irq_or: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rt_irq_i || (hw_pend & hw_line_reg) != 16'h0000) |=> !irq_n_o)
    else $error("interrupt line not asserted");
  a_summary_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pend_rd |=> reg_rdata_o[2] == $past(rt_pend_any_i))
    else $error("summary bit does not follow terminal pending");
  a_busy_alone: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rt_v_reg && (rt_event_i & ilh_pkg::EVT_MASK) == 16'h0000) |=> !rt_v_reg)
    else $error("terminal record without terminal event");
  a_busy_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rt_v_reg && busy_tag_reg && (rt_event_i & ilh_pkg::EVT_MASK) != 16'h0000)
      |=> rt_q_reg.ident[9] == $past(rt_busy_i) && rt_q_reg.ident[2])
    else $error("busy flag or terminal mark wrong");
  a_rt_loc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rt_v_reg && (rt_event_i & ilh_pkg::EVT_MASK) != 16'h0000)
      |=> rt_q_reg.loc == $past(rt_desc_addr_i))
    else $error("terminal location word wrong");
  a_hw_loc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!hw_v_reg && !par_log && hw_log != 16'h0000) |=> hw_q_reg.loc == 16'h0000)
    else $error("hardware location word not zero");
  a_par_loc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    par_log |=> hw_v_reg && hw_q_reg.loc == $past(ram_parity_addr_i))
    else $error("parity address not recorded");
  a_hw_ident: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!hw_v_reg && hw_log != 16'h0000) |=> hw_q_reg.ident == $past(hw_log))
    else $error("hardware ident word wrong");

  // checks on the triplet and the record queues
  // a hardware record only starts from an enabled event
  a_hw_gated: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!hw_v_reg && hw_log == 16'h0000) |=> !hw_v_reg)
    else $error("hardware record without enabled event");
  // a new pending bit needs an event and its enable one cycle earlier
  a_pend_enabled: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    1'b1 |=> (hw_pend & ~$past(hw_pend) & ~($past(hw_evt) & $past(hw_en_reg))) == 16'h0000)
    else $error("pending flag set by a disabled event");
  // the framing event lands in bit 15
  a_framing_pend: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (host_serial_framing_event_i && hw_en_reg[15]) |=> hw_pend[15])
    else $error("framing event not captured");
  // bits 2:0 are never stored in the triplet
  a_low_bits: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hw_en_reg[2:0] | hw_line_reg[2:0] | hw_pend[2:0]) == 3'h0)
    else $error("low bits stored in hardware triplet");
  // a hardware ident never carries the terminal mark
  a_hw_mark: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hw_v_reg |-> hw_q_reg.ident[2:0] == 3'h0)
    else $error("hardware ident word has low bits set");
  // untagged terminal ident: event bits and the mark, nothing else
  a_rt_ident: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rt_v_reg && !busy_tag_reg && (rt_event_i & ilh_pkg::EVT_MASK) != 16'h0000)
      |=> rt_q_reg.ident == (($past(rt_event_i) & ilh_pkg::EVT_MASK) | 16'h0004))
    else $error("terminal ident word wrong");
  // a waiting record keeps every bit it has gathered
  a_merge_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    hw_keep |=> (hw_q_reg.ident & $past(hw_q_reg.ident)) == $past(hw_q_reg.ident))
    else $error("waiting record lost an event bit");
  // a waiting record keeps its location unless parity fails
  a_loc_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (hw_keep && !par_log) |=> hw_q_reg.loc == $past(hw_q_reg.loc))
    else $error("waiting location word changed");
  // busy with no event leaves a waiting terminal record alone
  a_rt_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rt_keep && (rt_event_i & ilh_pkg::EVT_MASK) == 16'h0000) |=> rt_q_reg == $past(rt_q_reg))
    else $error("terminal record changed by busy alone");
  // no cause leaves the shared line high
  a_irq_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!rt_irq_i && (hw_pend & hw_line_reg) == 16'h0000) |=> irq_n_o)
    else $error("interrupt line asserted without cause");
  // a pending read shows the view and keeps only this cycle's events
  a_pend_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pend_rd |=> reg_rdata_o == $past(hw_pend_view) && hw_pend == $past(hw_log))
    else $error("pending read value or clear wrong");
  // a count read shows count and pointer as they stood
  a_count_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cnt_rd |=> reg_rdata_o == $past(cnt_ptr))
    else $error("count and pointer read wrong");
  // the writer is busy for exactly the two words of a record
  a_two_words: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (wr_ready && (rt_v_reg || hw_v_reg)) |=> !wr_ready ##1 !wr_ready ##1 wr_ready)
    else $error("record did not take two write cycles");

  c_multi_rt: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    $countones(rt_event_i & ilh_pkg::EVT_MASK) > 1);
  c_parity: cover property (@(posedge mclk_i) disable iff (sys_rst_i) par_log);
  c_irq: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $fell(irq_n_o));
  // a new event folding into a record that still waits
  c_merge: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    hw_keep && hw_log != 16'h0000);
endmodule
`default_nettype wire

/* File: sim/ilh_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ilh_host_model (
  // clock
  input  wire logic        mclk_i,
  // register port toward the block
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic      [15:0] reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i
);
  // idle bus at time zero
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 16'hffff;
    reg_wdata_o = 16'hffff;
  end

  // one write; released address and data flip so no stale value looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge mclk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  // one read; data is registered, so it is taken just after the following edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    #1;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(posedge mclk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: sim/ilh_int_log_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ilh_int_log_tb;
  logic                 mclk_i;
  logic                 sys_rst_i;
  logic                 reg_rd_i;
  logic                 reg_wr_i;
  logic [15:0]          reg_addr_i;
  logic [15:0]          reg_wdata_i;
  logic [15:0]          reg_rdata_o;
  logic [15:0]          hw_event_i;
  logic                 host_serial_framing_event_i;
  logic                 ram_parity_fault_i;
  logic [15:0]          ram_parity_addr_i;
  logic [15:0]          rt_event_i;
  logic [15:0]          rt_desc_addr_i;
  logic                 rt_busy_i;
  logic                 rt_pend_any_i;
  logic                 rt_irq_i;
  logic                 irq_n_o;
  ilh_pkg::ilh_ram_wr_t ram_wr_o;
  logic [15:0]          logmem [0:511];
  logic [15:0]          rv;
  logic [8:0]           p;
  int                   num_errors;
  int                   checks;
  int                   recs;
  int                   cnt;
  int                   wcount;

  ilh_int_log uut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .hw_event_i(hw_event_i), .host_serial_framing_event_i(host_serial_framing_event_i),
    .ram_parity_fault_i(ram_parity_fault_i), .ram_parity_addr_i(ram_parity_addr_i),
    .rt_event_i(rt_event_i), .rt_desc_addr_i(rt_desc_addr_i), .rt_busy_i(rt_busy_i),
    .rt_pend_any_i(rt_pend_any_i), .rt_irq_i(rt_irq_i), .irq_n_o(irq_n_o), .ram_wr_o(ram_wr_o)
  );

  ilh_host_model host (
    .mclk_i(mclk_i), .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o)
  );

  // 100 MHz clock
  always #5 mclk_i = ~mclk_i;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // log RAM copy; every write must land inside the buffer
  always @(posedge mclk_i) begin
    if (ram_wr_o.we === 1'b1) begin
      logmem[ram_wr_o.addr[8:0]] <= ram_wr_o.data;
      wcount <= wcount + 1;
      chk(16'(ram_wr_o.addr >= 16'h0180 && ram_wr_o.addr <= 16'h01bf), 16'h0001);
    end
  end

  // one-cycle event pulse, then wait out the two-word record; p is where it should land
  task automatic ev(input logic [15:0] hw, input logic par, input logic [15:0] pa,
                    input logic [15:0] rt, input logic [15:0] da, input logic bz,
                    input logic fr, input logic logs, output logic [8:0] p);
    p = 9'h180 + 9'(2 * (recs % 32));
    @(posedge mclk_i);
    #1;
    hw_event_i = hw;
    ram_parity_fault_i = par;
    ram_parity_addr_i = pa;
    rt_event_i = rt;
    rt_desc_addr_i = da;
    rt_busy_i = bz;
    host_serial_framing_event_i = fr;
    @(posedge mclk_i);
    #1;
    hw_event_i = 16'h0000;
    ram_parity_fault_i = 1'b0;
    ram_parity_addr_i = ~pa;
    rt_event_i = 16'h0000;
    rt_desc_addr_i = ~da;
    rt_busy_i = ~bz;
    host_serial_framing_event_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    #1;
    if (logs) begin
      recs++;
      cnt = (cnt == 127) ? 127 : cnt + 1;
    end
    chk(16'(wcount), 16'(2 * recs));
  endtask

  task automatic t_reset();
    host.rd(ilh_pkg::ADDR_HW_EN, rv);
    chk(rv, 16'h6000);
    host.rd(ilh_pkg::ADDR_HW_LINE, rv);
    chk(rv, 16'h6000);
    // low bits written to the line enable are not stored
    host.wr(ilh_pkg::ADDR_HW_LINE, 16'h6007);
    host.rd(ilh_pkg::ADDR_HW_LINE, rv);
    chk(rv, 16'h6000);
    host.rd(ilh_pkg::ADDR_CNT_PTR, rv);
    chk(rv, 16'h0180);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h0000);
  endtask

  // framing event logged with a zero location word; read clears pending
  task automatic t_framing();
    host.wr(ilh_pkg::ADDR_HW_EN, 16'he000);
    ev(16'h0000, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1, p);
    chk(logmem[p], 16'h8000);
    chk(logmem[p + 9'h1], 16'h0000);
    chk({15'h0000, irq_n_o}, 16'h0001);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h8000);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h0000);
  endtask

  // disabled event is lost, enabling later recalls nothing
  task automatic t_disabled();
    ev(16'h1000, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, p);
    host.wr(ilh_pkg::ADDR_HW_EN, 16'hf000);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h0000);
  endtask

  // two line-enabled events at once: one record, one interrupt, parity address kept
  task automatic t_parity();
    ev(16'h2000, 1'b1, 16'h0abc, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1, p);
    chk(logmem[p], 16'h6000);
    chk(logmem[p + 9'h1], 16'h0abc);
    chk({15'h0000, irq_n_o}, 16'h0000);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h6000);
    repeat (2) @(posedge mclk_i);
    #1;
    chk({15'h0000, irq_n_o}, 16'h0001);
  endtask

  task automatic t_terminal();
    host.wr(ilh_pkg::ADDR_EXT_CFG, 16'h0004);
    host.rd(ilh_pkg::ADDR_EXT_CFG, rv);
    chk(rv, 16'h0004);
    rt_pend_any_i = 1'b1;
    ev(16'h0000, 1'b0, 16'h0000, 16'h0048, 16'h0420, 1'b1, 1'b0, 1'b1, p);
    chk(logmem[p], 16'h024c);
    chk(logmem[p + 9'h1], 16'h0420);
    ev(16'h0000, 1'b0, 16'h0000, 16'h0000, 16'h0777, 1'b1, 1'b0, 1'b0, p);
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h0004);
    rt_pend_any_i = 1'b0;
    host.rd(ilh_pkg::ADDR_HW_PEND, rv);
    chk(rv, 16'h0000);
    // busy tagging off: busy must not show in the ident word
    host.wr(ilh_pkg::ADDR_EXT_CFG, 16'h0000);
    ev(16'h0000, 1'b0, 16'h0000, 16'h0010, 16'h0440, 1'b1, 1'b0, 1'b1, p);
    chk(logmem[p], 16'h0014);
    // a terminal line request alone pulls the shared output low
    rt_irq_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk({15'h0000, irq_n_o}, 16'h0000);
    rt_irq_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk({15'h0000, irq_n_o}, 16'h0001);
  endtask

  // 130 records: pointer wraps four times and the count saturates
  task automatic t_wrap();
    host.rd(ilh_pkg::ADDR_CNT_PTR, rv);
    chk(rv, {7'(cnt), 9'h180 + 9'(2 * (recs % 32))});
    cnt = 0;
    for (int i = 0; i < 130; i++) begin
      ev(16'h0000, 1'b1, 16'(i), 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1, p);
      chk(logmem[p + 9'h1], 16'(i));
    end
    host.rd(ilh_pkg::ADDR_CNT_PTR, rv);
    chk(rv, {7'h7f, 9'h180 + 9'(2 * (recs % 32))});
    host.rd(ilh_pkg::ADDR_CNT_PTR, rv);
    chk(rv, {7'h00, 9'h180 + 9'(2 * (recs % 32))});
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    conclude();
  end

  // main sequence: 20-cycle reset, then the scenarios
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    hw_event_i = 16'h0000;
    host_serial_framing_event_i = 1'b0;
    ram_parity_fault_i = 1'b0;
    ram_parity_addr_i = 16'h0000;
    rt_event_i = 16'h0000;
    rt_desc_addr_i = 16'h0000;
    rt_busy_i = 1'b0;
    rt_pend_any_i = 1'b0;
    rt_irq_i = 1'b0;
    num_errors = 0;
    checks = 0;
    recs = 0;
    cnt = 0;
    wcount = 0;
    repeat (20) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_framing();
    t_disabled();
    t_parity();
    t_terminal();
    t_wrap();
    conclude();
  end
endmodule
`default_nettype wire
